// ==== design/cmp_ctrl_pkg.sv ====
// Constants, field layouts and carrier types for the comparator control block
package cmp_ctrl_pkg;

   // ==========================================================
   // Register map (byte addresses, APB word aligned)
   localparam logic [7:0] CON0_BASE   = 8'h00;
   localparam logic [7:0] CON1_BASE   = 8'h04;
   localparam logic [7:0] CMP_STRIDE  = 8'h08;
   localparam logic [7:0] MIRROR_OFS  = 8'h10;
   localparam logic [7:0] FLAG_OFS    = 8'h14;
   localparam logic [7:0] IRQ_EN_OFS  = 8'h18;

   // ==========================================================
   // First control register fields
   localparam int B_ON   = 7;
   localparam int B_RES  = 6;
   localparam int B_OE   = 5;
   localparam int B_INV  = 4;
   localparam int B_SP   = 2;
   localparam int B_HYS  = 1;
   localparam int B_SYNC = 0;

   // ==========================================================
   // Second control register fields
   localparam int B_RISE = 7;
   localparam int B_FALL = 6;
   localparam int B_PCH  = 4;
   localparam int B_NCH  = 0;

   // ==========================================================
   // Positive input codes
   localparam logic [1:0] PLUS_PIN    = 2'h0;
   localparam logic [1:0] PLUS_DAC    = 2'h1;
   localparam logic [1:0] PLUS_FIXREF = 2'h2;
   localparam logic [1:0] PLUS_GND    = 2'h3;

   localparam logic SP_RESET = 1'b1;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       on;
      logic       oe;
      logic       inv;
      logic       sp;
      logic       hys;
      logic       tsync;
      logic       rise;
      logic       fall;
      logic [1:0] pch;
      logic [1:0] nch;
   } ctrl_type;

   localparam ctrl_type CTRL_RESET = '{on: 1'b0, oe: 1'b0, inv: 1'b0,
      sp: SP_RESET, hys: 1'b0, tsync: 1'b0, rise: 1'b0, fall: 1'b0,
      pch: PLUS_PIN, nch: 2'h0};

   // Controls for the analog front end of one comparator
   typedef struct packed {
      logic       enable;
      logic       low_power;
      logic       hysteresis;
      logic [3:0] plus_route;
      logic [3:0] minus_route;
   } analog_ctrl_type;

   // Pin control of one comparator output pin
   typedef struct packed {
      logic data;
      logic override;
      logic drive_en;
   } pin_ctrl_type;

endpackage

// ==== design/cmp_ctrl.sv ====
// Comparator control logic with APB register access
// Overview
// Each comparator has two control words, a shared mirror word,
// a shared event flag word and a shared irq enable word.
// The analog decision arrives asynchronously and is synchronised
// before anything reads it, so every register here is on clk.
// The timer clocks are sampled too; their falling edge is found
// by comparing two samples, not by clocking on the timer clock.
// That costs a few cycles of delay against the real timer edge,
// which is fine while the timer clock is much slower than clk.
// A timer clock faster than a quarter of clk is not supported.
// Every output leaves through a flop, so outputs trail their
// source registers by one cycle.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
module cmp_ctrl #(
   parameter int NUM_CMP = 2
) (
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   // APB slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [7:0]                            paddr,
   input  wire logic [31:0]                           pwdata,
   output logic                                       pready,
   output logic [31:0]                                prdata,
   output logic                                       pslverr,
   // Analog front end
   input  wire logic [NUM_CMP-1:0]                    raw_above,
   output cmp_ctrl_pkg::analog_ctrl_type [NUM_CMP-1:0] analog,
   // Gate timer clocks and prescaler use
   input  wire logic                                  gate_clk_raw,
   input  wire logic                                  gate_clk_scaled,
   input  wire logic                                  gate_prescale_used,
   output logic [NUM_CMP-1:0]                         gate_source,
   // Output pins
   input  wire logic [NUM_CMP-1:0]                    pin_direction,
   output cmp_ctrl_pkg::pin_ctrl_type [NUM_CMP-1:0]    pin,
   // Shutdown sources and event flags
   output logic [NUM_CMP-1:0]                         shutdown_source,
   output logic [NUM_CMP-1:0]                         event_request
);

   // ==========================================================
   // State
   // ctrl holds the writable control fields of each comparator.
   // compare_result is the polarity-corrected result, read by
   // software and by the edge detectors; result_prev is its
   // value one cycle earlier, for those detectors.
   // sync_latch is the copy taken on a falling timer clock edge.
   // gclk_* carry the sampled timer clocks and their edge.
   cmp_ctrl_pkg::ctrl_type ctrl [NUM_CMP];
   logic [NUM_CMP-1:0]     compare_result;
   logic [NUM_CMP-1:0]     result_prev;
   logic [NUM_CMP-1:0]     sync_latch;
   logic [NUM_CMP-1:0]     compare_event_flag;
   logic [NUM_CMP-1:0]     compare_irq_enable;
   logic [NUM_CMP-1:0]     above_meta;
   logic [NUM_CMP-1:0]     above_sync;
   logic [1:0]             gclk_meta;
   logic [1:0]             gclk_sync;
   logic                   gclk_prev;
   logic                   gclk_sel;
   logic                   gclk_fall;
   logic                   access;
   logic                   wr_en;
   logic [NUM_CMP-1:0]     next_result;
   logic [NUM_CMP-1:0]     edge_hit;

   // ==========================================================
   // Helpers
   // route turns a two-bit select code into a one-hot switch set
   // and opens every switch while the comparator is off.
   // reg_addr gives the byte address of a per-comparator word;
   // it is shared by the write decode and the read decode, so
   // the two can never drift apart.
   // Both stay within eight bits for the default of two units.
   function automatic logic [3:0] route(input logic en, input logic [1:0] code);
      route = en ? (4'h1 << code) : 4'h0;
   endfunction

   function automatic logic [7:0] reg_addr(input logic [7:0] base, input int idx);
      reg_addr = base + 8'(idx) * cmp_ctrl_pkg::CMP_STRIDE;
   endfunction

   // ==========================================================
   // Synchronisers for the analog outputs and timer clocks
   // Two flops each; only the second flop is read by logic.
   // The analog output can change at any time, and a slowly
   // moving input may chatter, so metastability is likely here.
   // The two timer clocks share one stage pair; they are
   // unrelated to clk and to each other.
   // Reset clears both stages so no false edge follows reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         above_meta <= '0;
         above_sync <= '0;
         gclk_meta  <= 2'h0;
         gclk_sync  <= 2'h0;
      end else begin
         above_meta <= raw_above;
         above_sync <= above_meta;
         gclk_meta  <= {gate_clk_scaled, gate_clk_raw};
         gclk_sync  <= gclk_meta;
      end
   end

   // Latch clock follows the prescaled clock when the prescaler is in use
   // The choice is made after the synchronisers, so switching the
   // prescaler use never exposes an unsynchronised clock.
   // Switching between two clocks in different phases can look
   // like a falling edge once; software should switch with sync off.
   // gclk_prev resets low, matching the idle level of the clocks,
   // so the first cycle after reset never shows a falling edge.
   assign gclk_sel  = gate_prescale_used ? gclk_sync[1] : gclk_sync[0];
   assign gclk_fall = gclk_prev & ~gclk_sel;

   always_ff @(posedge clk) begin
      if (rst) begin
         gclk_prev <= 1'b0;
      end else begin
         gclk_prev <= gclk_sel;
      end
   end

   // ==========================================================
   // Result path: a disabled comparator reads as low before inversion,
   // The edge detectors compare the registered result against its
   // value a cycle earlier, so an edge is seen once per change.
   // Rise and fall are qualified separately by their enables.
   // The invert bit applies even while the comparator is off;
   // this is what lets software raise a flag with no input.
   // so toggling on or invert still gives an edge
   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         next_result[i] = (ctrl[i].on & above_sync[i]) ^ ctrl[i].inv;
         edge_hit[i] = (ctrl[i].rise & compare_result[i] & ~result_prev[i])
                     | (ctrl[i].fall & ~compare_result[i] & result_prev[i]);
      end
   end

   // Internal copy refreshed on every clock
   // This copy feeds the readable bits, the mirror word, the edge
   // detectors, the shutdown outputs and the timer gate.
   // Holding one copy keeps all of them consistent in a cycle.
   // After the comparator is switched on, software should read
   // the result once before acting on it; it settles late.
   always_ff @(posedge clk) begin
      if (rst) begin
         compare_result <= '0;
         result_prev    <= '0;
      end else begin
         compare_result <= next_result;
         result_prev    <= compare_result;
      end
   end

   // Falling edge of the timer clock keeps clear of its rising increment
   // The latch runs whether or not sync mode is chosen; only the
   // output select looks at the mode bit.
   // Turning sync mode on therefore shows the last latched value
   // at once, not the live result, until the next falling edge.
   // Software that gates the timer should keep sync mode on.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_latch <= '0;
      end else if (gclk_fall) begin
         sync_latch <= compare_result;
      end
   end

   // ==========================================================
   // APB access strobes; answer one cycle into the access phase
   // access is high for one cycle per transfer: the first access
   // phase cycle. pready follows it one cycle later and then masks
   // access, so a held request is never taken twice.
   // Every transfer therefore lasts a setup cycle and two access
   // cycles; back to back transfers are accepted.
   assign access = psel & penable & ~pready;
   assign wr_en  = access & pwrite;

   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   // Control registers
   // Writes take effect at the edge that takes the access.
   // Unused bits of a written word are dropped; the result bit
   // of the first control word is read only.
   // The speed bit resets to normal speed, all others to zero.
   // Writes to unmapped addresses change nothing.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            ctrl[i] <= cmp_ctrl_pkg::CTRL_RESET;
         end
         compare_irq_enable <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (wr_en && paddr == reg_addr(cmp_ctrl_pkg::CON0_BASE, i)) begin
               ctrl[i].on    <= pwdata[cmp_ctrl_pkg::B_ON];
               ctrl[i].oe    <= pwdata[cmp_ctrl_pkg::B_OE];
               ctrl[i].inv   <= pwdata[cmp_ctrl_pkg::B_INV];
               ctrl[i].sp    <= pwdata[cmp_ctrl_pkg::B_SP];
               ctrl[i].hys   <= pwdata[cmp_ctrl_pkg::B_HYS];
               ctrl[i].tsync <= pwdata[cmp_ctrl_pkg::B_SYNC];
            end else if (wr_en && paddr == reg_addr(cmp_ctrl_pkg::CON1_BASE, i)) begin
               ctrl[i].rise <= pwdata[cmp_ctrl_pkg::B_RISE];
               ctrl[i].fall <= pwdata[cmp_ctrl_pkg::B_FALL];
               ctrl[i].pch  <= pwdata[cmp_ctrl_pkg::B_PCH +: 2];
               ctrl[i].nch  <= pwdata[cmp_ctrl_pkg::B_NCH +: 2];
            end
         end
         if (wr_en && paddr == cmp_ctrl_pkg::IRQ_EN_OFS) begin
            compare_irq_enable <= pwdata[NUM_CMP-1:0];
         end
      end
   end

   // Event flags: a zero written clears, a new edge in that cycle wins
   // Writing a one leaves a flag alone, so software can clear one
   // comparator's flag without a read-modify-write race on the
   // other. An edge in the clearing cycle keeps its flag set,
   // so an event is never lost to a clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         compare_event_flag <= '0;
      end else if (wr_en && paddr == cmp_ctrl_pkg::FLAG_OFS) begin
         compare_event_flag <= (compare_event_flag & pwdata[NUM_CMP-1:0])
                             | edge_hit;
      end else begin
         compare_event_flag <= compare_event_flag | edge_hit;
      end
   end

   // ==========================================================
   // Read data; unmapped addresses at or above the mirror word answer zero with an error
   // Read data is loaded at the taking edge and stands with pready.
   // It holds its value until the next access is taken.
   // Offsets below the mirror word that name no register read
   // zero, with an error only past the last comparator's words.
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= cmp_ctrl_pkg::ZERO_WORD;
         pslverr <= 1'b0;
      end else if (access) begin
         prdata  <= cmp_ctrl_pkg::ZERO_WORD;
         pslverr <= 1'b0;
         if (paddr == cmp_ctrl_pkg::MIRROR_OFS) begin
            prdata[NUM_CMP-1:0] <= compare_result;
         end else if (paddr == cmp_ctrl_pkg::FLAG_OFS) begin
            prdata[NUM_CMP-1:0] <= compare_event_flag;
         end else if (paddr == cmp_ctrl_pkg::IRQ_EN_OFS) begin
            prdata[NUM_CMP-1:0] <= compare_irq_enable;
         end else if (paddr >= cmp_ctrl_pkg::MIRROR_OFS) begin
            pslverr <= 1'b1;
         end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
               if (paddr == reg_addr(cmp_ctrl_pkg::CON0_BASE, i)) begin
                  prdata[cmp_ctrl_pkg::B_ON]   <= ctrl[i].on;
                  prdata[cmp_ctrl_pkg::B_RES]  <= compare_result[i];
                  prdata[cmp_ctrl_pkg::B_OE]   <= ctrl[i].oe;
                  prdata[cmp_ctrl_pkg::B_INV]  <= ctrl[i].inv;
                  prdata[cmp_ctrl_pkg::B_SP]   <= ctrl[i].sp;
                  prdata[cmp_ctrl_pkg::B_HYS]  <= ctrl[i].hys;
                  prdata[cmp_ctrl_pkg::B_SYNC] <= ctrl[i].tsync;
               end else if (paddr == reg_addr(cmp_ctrl_pkg::CON1_BASE, i)) begin
                  prdata[cmp_ctrl_pkg::B_RISE]       <= ctrl[i].rise;
                  prdata[cmp_ctrl_pkg::B_FALL]       <= ctrl[i].fall;
                  prdata[cmp_ctrl_pkg::B_PCH +: 2]   <= ctrl[i].pch;
                  prdata[cmp_ctrl_pkg::B_NCH +: 2]   <= ctrl[i].nch;
               end
            end
            if (paddr >= reg_addr(cmp_ctrl_pkg::CON0_BASE, NUM_CMP)) begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Analog front end controls; every input opens while the comparator is off
   // The enable also parks the comparator at minimum current.
   // Low power is the inverse of the speed bit and may change at
   // any time; the front end only slows down.
   // Hysteresis passes through unchanged.
   always_ff @(posedge clk) begin
      if (rst) begin
         analog <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            analog[i].enable      <= ctrl[i].on;
            analog[i].low_power   <= ~ctrl[i].sp;
            analog[i].hysteresis  <= ctrl[i].hys;
            analog[i].plus_route  <= route(ctrl[i].on, ctrl[i].pch);
            analog[i].minus_route <= route(ctrl[i].on, ctrl[i].nch);
         end
      end
   end

   // ==========================================================
   // Timer gate, pin and shutdown outputs; one register stage so that
   // The pin override follows the output enable alone; the on bit
   // only gates the pin drive, together with the pin direction.
   // Shutdown sources are never latched to the timer clock.
   // event_request is the flag qualified by its irq enable.
   // every output comes from a flop, at the cost of one cycle of delay
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_source     <= '0;
         pin             <= '0;
         shutdown_source <= '0;
         event_request   <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            gate_source[i]  <= ctrl[i].tsync ? sync_latch[i]
                                             : compare_result[i];
            pin[i].data     <= ctrl[i].tsync ? sync_latch[i]
                                             : compare_result[i];
            pin[i].override <= ctrl[i].oe;
            pin[i].drive_en <= ctrl[i].oe & ~pin_direction[i] & ctrl[i].on;
         end
         shutdown_source <= compare_result;
         event_request   <= compare_event_flag & compare_irq_enable;
      end
   end

endmodule

// ==== dv/cmp_ctrl_sva.sv ====
// Port-level assertions for the comparator control block
module cmp_ctrl_sva #(
   parameter int NUM_CMP = 2
) (
   // Clock, reset and APB
   input wire logic                                         clk,
   input wire logic                                         rst,
   input wire logic                                         psel,
   input wire logic                                         penable,
   input wire logic                                         pwrite,
   input wire logic [7:0]                                   paddr,
   input wire logic [31:0]                                  pwdata,
   input wire logic                                         pready,
   // Analog controls and pins
   input wire cmp_ctrl_pkg::analog_ctrl_type [NUM_CMP-1:0]  analog,
   input wire logic [NUM_CMP-1:0]                           pin_direction,
   input wire cmp_ctrl_pkg::pin_ctrl_type [NUM_CMP-1:0]     pin
);
   // ==========================================================
   // Sequences and properties, comparator 0 watched in detail
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   // Register and output each add one cycle after the taking edge
   sequence s_con0_wr;
      s_taken ##0 (pwrite && paddr == cmp_ctrl_pkg::CON0_BASE);
   endsequence
   property p_answer;
      s_taken |=> pready ##1 !pready;
   endproperty
   property p_on;
      s_con0_wr |=> ##1 analog[0].enable == $past(pwdata[cmp_ctrl_pkg::B_ON], 2);
   endproperty
   property p_sp;
      s_con0_wr |=> ##1 analog[0].low_power == !$past(pwdata[cmp_ctrl_pkg::B_SP], 2);
   endproperty
   property p_oe;
      s_con0_wr |=> ##1 pin[0].override == $past(pwdata[cmp_ctrl_pkg::B_OE], 2);
   endproperty
   property p_off;
      !analog[0].enable |-> analog[0].plus_route == 4'h0 && analog[0].minus_route == 4'h0;
   endproperty
   property p_routes;
      analog[0].enable |-> $onehot(analog[0].plus_route) && $onehot(analog[0].minus_route);
   endproperty
   property p_drive;
      pin[0].drive_en == (pin[0].override && analog[0].enable && !$past(pin_direction[0]));
   endproperty
   property p_sp_reset;
      $past(rst) |-> !analog[0].low_power;
   endproperty
   a_answer: assert property (p_answer) else $error("apb answer timing wrong");
   a_on: assert property (p_on) else $error("enable does not follow on bit");
   a_sp: assert property (p_sp) else $error("low power does not follow");
   a_oe: assert property (p_oe) else $error("override does not follow");
   a_off: assert property (p_off) else $error("inputs routed while off");
   a_routes: assert property (p_routes) else $error("route not one-hot");
   a_drive: assert property (p_drive) else $error("pin drive enable wrong");
   a_sp_reset: assert property (p_sp_reset) else $error("speed bit reset wrong");
endmodule

// ==== dv/analog_model.sv ====
// Behavioural analog front end: picks the routed levels and compares them
module analog_model #(
   parameter int NUM_CMP = 2
) (
   // Clock and routing from the block
   input  wire logic                                         clk,
   input  wire cmp_ctrl_pkg::analog_ctrl_type [NUM_CMP-1:0]  analog,
   // Levels at pins and references
   input  wire logic [NUM_CMP-1:0][7:0]                      vpin,
   input  wire logic [7:0]                                   vdac,
   input  wire logic [7:0]                                   vfix,
   input  wire logic [3:0][7:0]                              vneg,
   // Decisions
   output logic [NUM_CMP-1:0]                                raw_above
);
   logic [NUM_CMP-1:0] now_above;
   logic [NUM_CMP-1:0] slow_above = '0;
   logic [NUM_CMP-1:0] held       = '0;
   logic [7:0]         vp;
   logic [7:0]         vm;
   // One-hot routes pick the levels; plus code 3 is ground
   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         vp = analog[i].plus_route[0] ? vpin[i] : analog[i].plus_route[1] ? vdac :
              analog[i].plus_route[2] ? vfix : 8'h00;
         vm = 8'h00;
         for (int j = 0; j < 4; j++) begin
            if (analog[i].minus_route[j]) begin
               vm = vneg[j];
            end
         end
         now_above[i] = vp > vm;
      end
   end
   // Low power answers a cycle late; a disconnected output wanders every cycle
   always @(posedge clk) begin
      slow_above <= now_above;
      for (int i = 0; i < NUM_CMP; i++) begin
         if (!analog[i].enable) begin
            held[i] <= ~held[i];
         end else begin
            held[i] <= analog[i].low_power ? slow_above[i] : now_above[i];
         end
      end
   end
   assign raw_above = held;
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the comparator control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Signals and scoreboard
   logic                              clk = 1'b0;
   logic                              rst = 1'b1;
   logic                              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]                        paddr = 8'h00;
   logic [31:0]                       pwdata = 32'h0000_0000, prdata;
   logic                              pready, pslverr;
   logic                              gate_clk_raw = 1'b0, gate_clk_scaled = 1'b0;
   logic                              gate_prescale_used = 1'b0;
   logic [1:0]                        pin_direction = 2'h0, raw_above, gate_source;
   logic [1:0]                        shutdown_source, event_request;
   logic [1:0][7:0]                   vpin = '0;
   logic [7:0]                        vdac = 8'h00, vfix = 8'h00;
   logic [3:0][7:0]                   vneg = '0;
   cmp_ctrl_pkg::analog_ctrl_type [1:0] analog;
   cmp_ctrl_pkg::pin_ctrl_type [1:0]  pin;
   logic [32:0]                       exp_q[$];
   int                                fail_count = 0, compares = 0, cycles = 0;
   cmp_ctrl #(.NUM_CMP(2)) i_cmp_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .raw_above, .analog, .gate_clk_raw, .gate_clk_scaled,
      .gate_prescale_used, .gate_source, .pin_direction, .pin, .shutdown_source, .event_request);
   analog_model #(.NUM_CMP(2)) i_analog_model (.clk, .analog, .vpin, .vdac, .vfix, .vneg,
      .raw_above);
   always #5 clk = ~clk;
   // Hang guard far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   // Read answers are matched against the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check({pslverr, prdata}, exp_q.pop_front());
      end
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One APB transfer; an idle cycle follows so psel is never set twice at one edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      int n;
      n = 0;
      if (!wr) begin
         exp_q.push_back(exp);
      end
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // One timer clock pulse, raw or prescaled
   task automatic pulse(input logic scaled);
      if (scaled) begin
         gate_clk_scaled <= 1'b1;
      end else begin
         gate_clk_raw <= 1'b1;
      end
      repeat (4) @(posedge clk);
      gate_clk_raw <= 1'b0;
      gate_clk_scaled <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   function automatic logic res(input int k, input logic inv);
      logic [7:0] p;
      p = k == 0 ? vpin[0] : k == 1 ? vdac : k == 2 ? vfix : 8'h00;
      return (p > vneg[k]) ^ inv;
   endfunction
   // ==========================================================
   // Main sequence
   initial begin
      logic r;
      void'($urandom(32'h3156_8745));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, cmp_ctrl_pkg::CON0_BASE, 0, 33'h0_0000_0004);
      apb(0, 8'h1C, 0, 33'h1_0000_0000);
      // Every input code with random levels; odd codes invert
      for (int k = 0; k < 4; k++) begin
         {vpin, vdac, vfix, vneg} <= {$urandom, $urandom};
         pin_direction[0] <= k[1];
         apb(1, cmp_ctrl_pkg::CON1_BASE, 32'(k * 17), 0);
         apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_00A4 | 32'(k[0]) << 4, 0);
         repeat (6) @(posedge clk);
         r = res(k, k[0]);
         apb(0, cmp_ctrl_pkg::CON0_BASE, 0, {25'h0, 1'b1, r, 1'b1, k[0], 4'h4});
         apb(0, cmp_ctrl_pkg::MIRROR_OFS, 0, {32'h0, r});
         check(33'(analog[0].plus_route), 33'(4'h1 << k));
         check(33'(analog[0].minus_route), 33'(4'h1 << k));
         check(33'(pin[0]), 33'({r, 1'b1, !k[1]}));
         check(33'({gate_source[0], shutdown_source[0]}), 33'({r, r}));
      end
      // Off with output enable, hysteresis and low power
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0022, 0);
      repeat (4) @(posedge clk);
      check(33'(analog[0]), 33'(11'h300));
      check(33'(pin[0]), 33'(3'b010));
      // Invert toggles while off make edges; a clear sticks until the next enabled edge
      apb(1, cmp_ctrl_pkg::IRQ_EN_OFS, 32'h0000_0001, 0);
      apb(1, cmp_ctrl_pkg::CON1_BASE, 32'h0000_0080, 0);
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0014, 0);
      repeat (6) @(posedge clk);
      check(33'(event_request[0]), 33'h1);
      apb(0, cmp_ctrl_pkg::FLAG_OFS, 0, 33'h1);
      apb(1, cmp_ctrl_pkg::FLAG_OFS, 0, 0);
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0004, 0);
      repeat (6) @(posedge clk);
      apb(0, cmp_ctrl_pkg::FLAG_OFS, 0, 33'h0);
      apb(1, cmp_ctrl_pkg::CON1_BASE, 32'h0000_0040, 0);
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0014, 0);
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0004, 0);
      repeat (6) @(posedge clk);
      apb(0, cmp_ctrl_pkg::FLAG_OFS, 0, 33'h1);
      // Synchronous mode holds the timer result between falling timer clock edges
      vpin[0] <= 8'h80;
      vneg[0] <= 8'h10;
      apb(1, cmp_ctrl_pkg::CON1_BASE, 0, 0);
      apb(1, cmp_ctrl_pkg::CON0_BASE, 32'h0000_0085, 0);
      pulse(1'b0);
      check(33'(gate_source[0]), 33'h1);
      vpin[0] <= 8'h00;
      repeat (8) @(posedge clk);
      check(33'({gate_source[0], shutdown_source[0]}), 33'h2);
      pulse(1'b0);
      check(33'(gate_source[0]), 33'h0);
      gate_prescale_used <= 1'b1;
      vpin[0] <= 8'h80;
      pulse(1'b0);
      check(33'(gate_source[0]), 33'h0);
      pulse(1'b1);
      check(33'(gate_source[0]), 33'h1);
      finish_test();
   end
endmodule
bind cmp_ctrl cmp_ctrl_sva #(.NUM_CMP(NUM_CMP)) i_cmp_ctrl_sva (.clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .analog, .pin_direction, .pin);
